// [bench/test_tkc_touch_key_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tkc_consts.svh"
`define CHK(g, e) check(32'(g), 32'(e));
module test_tkc_touch_key_control;
   // clock, reset and apb
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   // oscillators and pad control
   logic ref_clock, sense_osc_clock, sense_osc_enable, ref_osc_enable, sense_clock_doubler;
   logic [3:0] pad_osc_switch, pad_ground_switch, pad_digital_off;
   logic ref_pad_switch, ref_pad_digital_off, gated_sense_clock, touch_irq, g_prev;
   logic [1:0] div;
   int num_errors = 0, tests_run = 0, irq_cnt = 0, gcnt = 0, g0, n;
   tkc_touch_key_control dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_clock(ref_clock),
      .sense_osc_clock(sense_osc_clock), .sense_osc_enable(sense_osc_enable),
      .ref_osc_enable(ref_osc_enable), .sense_clock_doubler(sense_clock_doubler),
      .pad_osc_switch(pad_osc_switch), .pad_ground_switch(pad_ground_switch),
      .pad_digital_off(pad_digital_off), .ref_pad_switch(ref_pad_switch),
      .ref_pad_digital_off(ref_pad_digital_off), .gated_sense_clock(gated_sense_clock),
      .touch_irq(touch_irq));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // sensor oscillator runs at a quarter of pclk so the synchroniser never drops edges
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn) div <= 2'h0;
      else div <= div + 2'h1;
   end
   assign sense_osc_clock = div[1];
   always @(posedge pclk)
   begin
      g_prev <= gated_sense_clock;
      if (touch_irq === 1'b1) irq_cnt++;
      if (gated_sense_clock === 1'b1 && g_prev === 1'b0) gcnt++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench watchdog limits the wait for pready
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge, so a following call never re-drives psel in this step
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      repeat (2) @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
   endtask
   // one reference oscillator period of four pclk cycles per edge
   task automatic ref_edges(input int cnt);
      repeat (cnt)
      begin
         ref_clock <= 1'b1;
         repeat (2) @(posedge pclk);
         ref_clock <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask
   task automatic final_report();
      $display("checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (50000) @(posedge pclk);
      num_errors++;
      final_report();
   end
   initial
   begin
      logic [31:0] r;
      logic e;
      {presetn, psel, penable, pwrite, paddr, pwdata, ref_clock} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TKC_ADDR_CTRL1, 32'h0);
      rd(`TKC_ADDR_CTRL0, 32'h0);
      apb(1'b0, 12'h010, 32'h0, r, e);
      `CHK(e, 1'b1)
      `CHK(r, 32'h0)
      wr(`TKC_ADDR_PINSEL, 32'hf);
      rd(`TKC_ADDR_PINSEL, 32'hf);
      for (int s = 0; s < 4; s++)
      begin
         wr(`TKC_ADDR_CTRL0, 32'(s));
         `CHK(pad_osc_switch, 4'h1 << s)
         `CHK(pad_ground_switch, 4'(~(4'h1 << s)))
         `CHK(pad_digital_off, 4'hf)
      end
      wr(`TKC_ADDR_PINSEL, 32'h5);
      `CHK({pad_osc_switch, pad_ground_switch, pad_digital_off}, 12'h055)
      wr(`TKC_ADDR_CTRL0, 32'hc4);
      `CHK({ref_osc_enable, sense_osc_enable, sense_clock_doubler}, 3'h7)
      wr(`TKC_ADDR_CTRL0, 32'h0);
      `CHK({ref_osc_enable, sense_osc_enable, sense_clock_doubler}, 3'h0)
      // software cannot force the overflow flag
      wr(`TKC_ADDR_CTRL1, 32'h6);
      rd(`TKC_ADDR_CTRL1, 32'h4);
      `CHK({ref_pad_switch, ref_pad_digital_off}, 2'h3)
      wr(`TKC_ADDR_CTRL1, 32'h0);
      `CHK({ref_pad_switch, ref_pad_digital_off}, 2'h0)
      wr(`TKC_ADDR_PINSEL, 32'hf);
      for (int p = 0; p < 4; p++)
      begin
         n = 512 << p;
         wr(`TKC_ADDR_CTRL0, 32'hc0 | (p << 3) | 32'h20);
         wr(`TKC_ADDR_CTRL0, 32'hc0 | (p << 3));
         rd(`TKC_ADDR_COUNT, 32'h0);
         wr(`TKC_ADDR_CTRL1, 32'h5);
         wr(`TKC_ADDR_CTRL1, 32'h4);
         rd(`TKC_ADDR_CTRL1, 32'h4);
         g0 = gcnt;
         ref_edges(n / 2);
         // a second start mid-period must not disturb the run
         wr(`TKC_ADDR_CTRL1, 32'h5);
         wr(`TKC_ADDR_CTRL1, 32'h4);
         ref_edges(n / 2 - 1);
         repeat (6) @(posedge pclk);
         rd(`TKC_ADDR_COUNT, 32'(n - 1));
         rd(`TKC_ADDR_CTRL1, 32'h4);
         `CHK(gcnt > g0, 1'b1)
         `CHK(irq_cnt, p)
         ref_edges(1);
         repeat (6) @(posedge pclk);
         rd(`TKC_ADDR_CTRL1, 32'h6);
         `CHK(irq_cnt, p + 1)
         g0 = gcnt;
         repeat (20) @(posedge pclk);
         `CHK({gcnt == g0, gated_sense_clock}, 2'h2)
      end
      final_report();
   end
endmodule
`default_nettype wire

// [design/tkc_consts.svh]
`ifndef TKC_CONSTS_SVH
`define TKC_CONSTS_SVH
// register byte addresses
`define TKC_ADDR_CTRL0 12'h000
`define TKC_ADDR_CTRL1 12'h004
`define TKC_ADDR_PINSEL 12'h008
`define TKC_ADDR_COUNT 12'h00c
// ctrl0 fields
`define TKC_C0_PAD_LO 0
`define TKC_C0_DBL 2
`define TKC_C0_PER_LO 3
`define TKC_C0_CLR 5
`define TKC_C0_SENSE_OSC_ENABLE 6
`define TKC_C0_REF_OSC_ENABLE 7
// ctrl1 fields
`define TKC_C1_START 0
`define TKC_C1_OVF 1
`define TKC_C1_REFPAD 2
// reset values
`define TKC_RST_CTRL0 8'h00
`define TKC_RST_CTRL1 3'h0
`define TKC_RST_PINSEL 4'h0
// reference period terminal counts, minus one
`define TKC_PER_512 12'h1ff
`define TKC_PER_1024 12'h3ff
`define TKC_PER_2048 12'h7ff
`define TKC_PER_4096 12'hfff
`define TKC_CNT_ZERO 12'h000
`define TKC_CNT_ONE 12'h001
`endif

// [design/tkc_pkg.sv]
package tkc_pkg;
   typedef enum logic [1:0]
   {
      TKC_IDLE = 2'b01,
      TKC_RUN = 2'b10
   } tkc_state_t;
   typedef struct packed
   {
      logic [3:0] osc_sw;
      logic [3:0] gnd_sw;
      logic [3:0] dig_off;
   } tkc_pads_t;
endpackage

// [design/tkc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser with rising edge detect on the settled side
module tkc_sync
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // async in, sync out
   input wire logic async_in,
   output logic sync_out,
   output logic rise
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
   assign sync_out = sync_reg;
   assign rise = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// [design/tkc_touch_key_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tkc_consts.svh"
module tkc_touch_key_control
   import tkc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // oscillator clocks, asynchronous to pclk, resynchronised inside by tkc_sync
   input wire logic ref_clock,
   input wire logic sense_osc_clock,
   // analog and pin control
   output logic sense_osc_enable,
   output logic ref_osc_enable,
   output logic sense_clock_doubler,
   output logic [3:0] pad_osc_switch,
   output logic [3:0] pad_ground_switch,
   output logic [3:0] pad_digital_off,
   output logic ref_pad_switch,
   output logic ref_pad_digital_off,
   // to timer and interrupt controller
   output logic gated_sense_clock,
   output logic touch_irq
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl0_reg;
   logic [2:0] ctrl1_reg;
   logic [3:0] pinsel_reg;
   logic ovf_reg;
   logic [11:0] count_reg;
   tkc_state_t state_reg;
   logic clr_last_reg;
   logic start_last_reg;
   logic sync_en_reg;
   tkc_pads_t pads_next;
   logic [11:0] term;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic clr_rise;
   logic start_rise;
   logic ref_s;
   logic ref_rise;
   logic sen_s;
   logic period_end;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign addr_ok = (paddr == `TKC_ADDR_CTRL0) | (paddr == `TKC_ADDR_CTRL1) |
                    (paddr == `TKC_ADDR_PINSEL) | (paddr == `TKC_ADDR_COUNT);
   ////////////////////////////////////////////////////////////////////////////
   // register writes; the overflow flag has no write path
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl0_reg <= `TKC_RST_CTRL0;
         ctrl1_reg <= `TKC_RST_CTRL1;
         pinsel_reg <= `TKC_RST_PINSEL;
      end
      else if (wr_en)
      begin
         if (paddr == `TKC_ADDR_CTRL0)
            ctrl0_reg <= pwdata[7:0];
         if (paddr == `TKC_ADDR_CTRL1)
            ctrl1_reg <= pwdata[2:0];
         if (paddr == `TKC_ADDR_PINSEL)
            pinsel_reg <= pwdata[3:0];
      end
   end
   // single-cycle answer: pready is always high, unmapped raises pslverr
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
         pready <= 1'b1;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= 1'b1;
         pslverr <= psel & ~penable & ~addr_ok;
         prdata <= 32'h0;
         if (psel & ~penable & ~pwrite)
         begin
            case (paddr)
               `TKC_ADDR_CTRL0: prdata <= {24'h0, ctrl0_reg};
               `TKC_ADDR_CTRL1: prdata <= {29'h0, ctrl1_reg[2], ovf_reg,
                                           ctrl1_reg[0]};
               `TKC_ADDR_PINSEL: prdata <= {28'h0, pinsel_reg};
               `TKC_ADDR_COUNT: prdata <= {20'h0, count_reg};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // edge detect of software bits
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clr_last_reg <= 1'b0;
         start_last_reg <= 1'b0;
      end
      else
      begin
         clr_last_reg <= ctrl0_reg[`TKC_C0_CLR];
         start_last_reg <= ctrl1_reg[`TKC_C1_START];
      end
   end
   assign clr_rise = ctrl0_reg[`TKC_C0_CLR] & ~clr_last_reg;
   assign start_rise = ctrl1_reg[`TKC_C1_START] & ~start_last_reg;
   ////////////////////////////////////////////////////////////////////////////
   // oscillator clocks are resynchronised; held off until a start
   tkc_sync u_ref_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(ref_clock & sync_en_reg),
      .sync_out(),
      .rise(ref_rise)
   );
   tkc_sync u_sen_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(sense_osc_clock & sync_en_reg),
      .sync_out(sen_s),
      .rise()
   );
   assign ref_s = ref_rise;
   always_comb
   begin
      case (ctrl0_reg[`TKC_C0_PER_LO +: 2])
         2'b00: term = `TKC_PER_512;
         2'b01: term = `TKC_PER_1024;
         2'b10: term = `TKC_PER_2048;
         default: term = `TKC_PER_4096;
      endcase
   end
   assign period_end = (state_reg == TKC_RUN) & ref_s & (count_reg == term);
   ////////////////////////////////////////////////////////////////////////////
   // measurement state; a start rise while running is dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= TKC_IDLE;
         sync_en_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            TKC_IDLE:
            begin
               if (start_rise)
               begin
                  state_reg <= TKC_RUN;
                  sync_en_reg <= 1'b1;
               end
            end
            TKC_RUN:
            begin
               if (period_end)
                  state_reg <= TKC_IDLE;
            end
            default: state_reg <= TKC_IDLE;
         endcase
      end
   end
   // reference counter: counts ref clock edges only while running
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_reg <= `TKC_CNT_ZERO;
      else if (clr_rise)
         count_reg <= `TKC_CNT_ZERO;
      else if (state_reg == TKC_RUN && ref_s && !period_end)
         count_reg <= count_reg + `TKC_CNT_ONE;
   end
   // overflow flag: the set wins over a clearing start in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovf_reg <= 1'b0;
      else if (period_end)
         ovf_reg <= 1'b1;
      else if (start_rise && state_reg == TKC_IDLE)
         ovf_reg <= 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // pad switching
   always_comb
   begin
      pads_next.osc_sw = 4'h0;
      pads_next.gnd_sw = 4'h0;
      for (int i = 0; i < 4; i++)
      begin
         if (pinsel_reg[i])
         begin
            pads_next.osc_sw[i] = (ctrl0_reg[`TKC_C0_PAD_LO +: 2] == i[1:0]);
            pads_next.gnd_sw[i] = (ctrl0_reg[`TKC_C0_PAD_LO +: 2] != i[1:0]);
         end
      end
      pads_next.dig_off = pinsel_reg;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pad_osc_switch <= 4'h0;
         pad_ground_switch <= 4'h0;
         pad_digital_off <= 4'h0;
         ref_pad_switch <= 1'b0;
         ref_pad_digital_off <= 1'b0;
         sense_osc_enable <= 1'b0;
         ref_osc_enable <= 1'b0;
         sense_clock_doubler <= 1'b0;
         gated_sense_clock <= 1'b0;
         touch_irq <= 1'b0;
      end
      else
      begin
         pad_osc_switch <= pads_next.osc_sw;
         pad_ground_switch <= pads_next.gnd_sw;
         pad_digital_off <= pads_next.dig_off;
         ref_pad_switch <= ctrl1_reg[`TKC_C1_REFPAD];
         ref_pad_digital_off <= ctrl1_reg[`TKC_C1_REFPAD];
         sense_osc_enable <= ctrl0_reg[`TKC_C0_SENSE_OSC_ENABLE];
         ref_osc_enable <= ctrl0_reg[`TKC_C0_REF_OSC_ENABLE];
         sense_clock_doubler <= ctrl0_reg[`TKC_C0_DBL];
         gated_sense_clock <= sen_s & (state_reg == TKC_RUN) & ~period_end;
         touch_irq <= period_end;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   a_ovf_on_end: assert property (@(posedge pclk) disable iff (!presetn)
      period_end |=> ovf_reg && touch_irq) else $error("flag or irq missed");
   a_start_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (start_rise && state_reg == TKC_IDLE) |=> !ovf_reg && state_reg == TKC_RUN)
      else $error("start did not clear flag");
   a_retrig_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == TKC_RUN && !period_end && !clr_rise) |=>
      count_reg == $past(count_reg) || count_reg == $past(count_reg) + `TKC_CNT_ONE)
      else $error("counter disturbed");
   a_clear_edge: assert property (@(posedge pclk) disable iff (!presetn)
      clr_rise |=> count_reg == `TKC_CNT_ZERO) else $error("clear missed");
   a_no_clear_level: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == TKC_IDLE && !clr_rise) |=> count_reg == $past(count_reg))
      else $error("idle counter moved");
   a_period_512: assert property (@(posedge pclk) disable iff (!presetn)
      (period_end && ctrl0_reg[`TKC_C0_PER_LO +: 2] == 2'b00) |-> count_reg == `TKC_PER_512)
      else $error("bad 512 end");
   a_io_open: assert property (@(posedge pclk) disable iff (!presetn)
      !pinsel_reg[0] |=> !pad_osc_switch[0] && !pad_ground_switch[0])
      else $error("io pad switch closed");
   a_one_pad: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0(pad_osc_switch) && ((pad_osc_switch & pad_ground_switch) == 4'h0))
      else $error("pad switch clash");
   a_gate_block: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg == TKC_IDLE) |=> !gated_sense_clock) else $error("clock leaked");
   a_osc_en: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 sense_osc_enable == $past(ctrl0_reg[`TKC_C0_SENSE_OSC_ENABLE])
      && ref_osc_enable == $past(ctrl0_reg[`TKC_C0_REF_OSC_ENABLE]))
      else $error("osc enable wrong");
   c_measure: cover property (@(posedge pclk) disable iff (!presetn) period_end);
   c_retrig: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == TKC_RUN && start_rise);
   c_clear: cover property (@(posedge pclk) disable iff (!presetn) clr_rise);
endmodule
`default_nettype wire
